// >>> hdl/crbt_defines.svh
// Register offsets, field positions, reset values and divider counts
`ifndef CRBT_DEFINES_SVH
`define CRBT_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CRBT_ADDR_CONTROL   8'hC9
`define CRBT_ADDR_CAP_LOW   8'hE4
`define CRBT_ADDR_CAP_HIGH  8'hE5
`define CRBT_ADDR_CNT_LOW   8'hF4
`define CRBT_ADDR_CNT_HIGH  8'hF5

// ----------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------
`define CRBT_BIT_OVF        7
`define CRBT_BIT_EXT        6
`define CRBT_BIT_RX_SEL     5
`define CRBT_BIT_TX_SEL     4
`define CRBT_BIT_EXT_EN     3
`define CRBT_BIT_RUN        2
`define CRBT_BIT_CT_SEL     1
`define CRBT_BIT_CAP_SEL    0

// ----------------------------------------------------------------
// Reset values and count limits
// ----------------------------------------------------------------
`define CRBT_CTRL_RESET     8'h00
`define CRBT_BYTE_RESET     8'h00
`define CRBT_CNT_MAX        16'hFFFF

// ----------------------------------------------------------------
// Timebase dividers
// ----------------------------------------------------------------
`define CRBT_DIV_SLOW       12
`define CRBT_DIV_BAUD       2

`endif

// >>> hdl/crbt_pkg.sv
// Types shared by the capture/reload/baud timer
`default_nettype none

package crbt_pkg;

  typedef logic [7:0] crbt_byte_t;
  typedef logic [15:0] crbt_word_t;

  typedef enum logic [1:0] {
    crbt_mode_off     = 2'b00,
    crbt_mode_capture = 2'b01,
    crbt_mode_reload  = 2'b10,
    crbt_mode_baud    = 2'b11
  } crbt_mode_t;

endpackage : crbt_pkg

`default_nettype wire

// >>> hdl/crbt_prescaler.sv
// Free-running divider giving the slow and baud timebase enables
`include "crbt_defines.svh"
`default_nettype none

module crbt_prescaler #(
  parameter int DIV_SLOW = `CRBT_DIV_SLOW,
  parameter int DIV_BAUD = `CRBT_DIV_BAUD
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Timebase enables
  output logic      slow_tick,
  output logic      baud_tick
);
  localparam int SW = $clog2(DIV_SLOW);
  localparam int BW = $clog2(DIV_BAUD);

  generate
    if (DIV_SLOW < 2 || DIV_BAUD < 2) begin : g_bad_div
      $error("crbt_prescaler: dividers must be at least 2");
    end
  endgenerate

  logic [SW-1:0] slow_cnt_reg;
  logic [BW-1:0] baud_cnt_reg;

  assign slow_tick = (slow_cnt_reg == SW'(DIV_SLOW - 1));
  assign baud_tick = (baud_cnt_reg == BW'(DIV_BAUD - 1));

  always_ff @(posedge clk) begin
    if (!resetn) begin
      slow_cnt_reg <= '0;
      baud_cnt_reg <= '0;
    end else begin
      slow_cnt_reg <= slow_tick ? '0 : slow_cnt_reg + SW'(1);
      baud_cnt_reg <= baud_tick ? '0 : baud_cnt_reg + BW'(1);
    end
  end

endmodule : crbt_prescaler

`default_nettype wire

// >>> hdl/crbt_pin_sync.sv
// Three-stage pin synchroniser with a one-pulse falling edge detector
`default_nettype none

module crbt_pin_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Pin and edge
  input  wire logic pin_in,
  output logic      pin_fall
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  logic agree;

  // Level only counts once the last two stages agree
  assign agree    = (s2_reg == s3_reg);
  assign pin_fall = agree && level_reg && !s3_reg;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_reg    <= 1'b1;
      s2_reg    <= 1'b1;
      s3_reg    <= 1'b1;
      level_reg <= 1'b1;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (agree) begin
        level_reg <= s3_reg;
      end
    end
  end

endmodule : crbt_pin_sync

`default_nettype wire

// >>> hdl/crbt_timer.sv
// Capture/reload/baud 16-bit counter timer with byte-wide registers
`include "crbt_defines.svh"
`default_nettype none

module crbt_timer
  import crbt_pkg::*;
#(
  parameter int DIV_SLOW = `CRBT_DIV_SLOW
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 resetn,
  // Special-function register access
  input  wire logic [7:0]           sfr_addr,
  input  wire crbt_pkg::crbt_byte_t sfr_wdata,
  input  wire logic                 sfr_wr,
  input  wire logic                 sfr_rd,
  output crbt_pkg::crbt_byte_t      sfr_rdata,
  output logic                      sfr_hit,
  // System configuration from outside the block
  input  wire logic                 clock_divide_select,
  input  wire logic                 timer_irq_enable,
  // External event pins
  input  wire logic                 count_pin,
  input  wire logic                 trigger_pin,
  // Second UART shift clocks
  input  wire logic                 other_timer_overflow,
  output logic                      uart_rx_shift_clk,
  output logic                      uart_tx_shift_clk,
  // Interrupt request and status
  output logic                      timer_irq_req,
  output crbt_pkg::crbt_mode_t      timer_mode
);
  import crbt_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  crbt_byte_t timer_control_reg;
  crbt_byte_t timer_control_next;
  crbt_byte_t capture_reload_low_reg;
  crbt_byte_t capture_reload_low_next;
  crbt_byte_t capture_reload_high_reg;
  crbt_byte_t capture_reload_high_next;
  crbt_byte_t count_low_reg;
  crbt_byte_t count_low_next;
  crbt_byte_t count_high_reg;
  crbt_byte_t count_high_next;
  crbt_byte_t sfr_rdata_reg;
  crbt_byte_t sfr_rdata_next;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  logic overflow_flag;
  logic external_flag;
  logic receive_clock_select;
  logic transmit_clock_select;
  logic external_enable;
  logic run_control;
  logic counter_timer_select;
  logic capture_reload_select;

  assign overflow_flag         = timer_control_reg[`CRBT_BIT_OVF];
  assign external_flag         = timer_control_reg[`CRBT_BIT_EXT];
  assign receive_clock_select  = timer_control_reg[`CRBT_BIT_RX_SEL];
  assign transmit_clock_select = timer_control_reg[`CRBT_BIT_TX_SEL];
  assign external_enable       = timer_control_reg[`CRBT_BIT_EXT_EN];
  assign run_control           = timer_control_reg[`CRBT_BIT_RUN];
  assign counter_timer_select  = timer_control_reg[`CRBT_BIT_CT_SEL];
  assign capture_reload_select = timer_control_reg[`CRBT_BIT_CAP_SEL];

  // ----------------------------------------------------------------
  // Pin synchronisers and timebase
  // ----------------------------------------------------------------
  logic [1:0] pin_raw;
  logic [1:0] pin_fall;
  logic       slow_tick;
  logic       baud_tick;

  assign pin_raw = {trigger_pin, count_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      crbt_pin_sync u_sync (
        .clk      (clk),
        .resetn   (resetn),
        .pin_in   (pin_raw[gi]),
        .pin_fall (pin_fall[gi])
      );
    end
  endgenerate

  crbt_prescaler #(
    .DIV_SLOW (DIV_SLOW),
    .DIV_BAUD (`CRBT_DIV_BAUD)
  ) u_prescaler (
    .clk       (clk),
    .resetn    (resetn),
    .slow_tick (slow_tick),
    .baud_tick (baud_tick)
  );

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic baud_mode;
  logic mode_capture;
  logic mode_reload;

  assign baud_mode = receive_clock_select | transmit_clock_select;
  assign mode_capture = run_control && !baud_mode
                        && capture_reload_select;
  assign mode_reload = run_control && !baud_mode
                       && !capture_reload_select;

  always_comb begin
    case ({run_control, baud_mode, capture_reload_select})
      3'b100:  timer_mode = crbt_mode_reload;
      3'b101:  timer_mode = crbt_mode_capture;
      3'b110:  timer_mode = crbt_mode_baud;
      3'b111:  timer_mode = crbt_mode_baud;
      default: timer_mode = crbt_mode_off;
    endcase
  end

  // ----------------------------------------------------------------
  // Count events
  // ----------------------------------------------------------------
  crbt_word_t count;
  crbt_word_t reload_value;
  crbt_word_t count_inc;
  crbt_word_t count_after;
  logic       sys_tick;
  logic       tick;
  logic       inc;
  logic       wrap;
  logic       trig;
  logic       capture_ev;
  logic       reload_ev;
  logic       ovf_set;
  logic       ext_set;
  logic       baud_ovf;

  assign count        = {count_high_reg, count_low_reg};
  assign reload_value = {capture_reload_high_reg,
                         capture_reload_low_reg};
  assign count_inc    = count + 16'h0001;

  // Timer function picks /1 or /12; baud mode forces /2
  assign sys_tick = baud_mode ? baud_tick :
                    (clock_divide_select ? 1'b1 : slow_tick);
  assign tick = counter_timer_select ? pin_fall[0] : sys_tick;
  assign inc  = run_control && tick;
  assign wrap = inc && (count == `CRBT_CNT_MAX);

  // Trigger edges are dropped while stopped or not enabled
  assign trig = run_control && external_enable && pin_fall[1];
  assign capture_ev = trig && mode_capture;
  assign reload_ev  = (wrap && !mode_capture)
                      || (trig && mode_reload);
  assign ovf_set  = wrap && !baud_mode;
  assign ext_set  = trig;
  assign baud_ovf = wrap && baud_mode;

  assign count_after = reload_ev ? reload_value :
                       (inc ? count_inc : count);

  // ----------------------------------------------------------------
  // UART shift clock routing
  // ----------------------------------------------------------------
  assign uart_rx_shift_clk = receive_clock_select ? baud_ovf
                             : other_timer_overflow;
  assign uart_tx_shift_clk = transmit_clock_select ? baud_ovf
                             : other_timer_overflow;

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  assign timer_irq_req = timer_irq_enable
                         && (overflow_flag || external_flag);

  // ----------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------
  logic hit_control;
  logic hit_cap_low;
  logic hit_cap_high;
  logic hit_cnt_low;
  logic hit_cnt_high;

  assign hit_control  = (sfr_addr == `CRBT_ADDR_CONTROL);
  assign hit_cap_low  = (sfr_addr == `CRBT_ADDR_CAP_LOW);
  assign hit_cap_high = (sfr_addr == `CRBT_ADDR_CAP_HIGH);
  assign hit_cnt_low  = (sfr_addr == `CRBT_ADDR_CNT_LOW);
  assign hit_cnt_high = (sfr_addr == `CRBT_ADDR_CNT_HIGH);
  assign sfr_hit      = hit_control | hit_cap_low | hit_cap_high
                        | hit_cnt_low | hit_cnt_high;
  assign sfr_rdata    = sfr_rdata_reg;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    // Flags: hardware set wins over a software clear
    timer_control_next = timer_control_reg;
    if (sfr_wr && hit_control) begin
      timer_control_next = sfr_wdata;
    end
    timer_control_next[`CRBT_BIT_OVF] =
      timer_control_next[`CRBT_BIT_OVF] | ovf_set;
    timer_control_next[`CRBT_BIT_EXT] =
      timer_control_next[`CRBT_BIT_EXT] | ext_set;

    // Count: software byte write overrides hardware update
    count_low_next  = count_after[7:0];
    count_high_next = count_after[15:8];
    if (sfr_wr && hit_cnt_low) begin
      count_low_next = sfr_wdata;
    end
    if (sfr_wr && hit_cnt_high) begin
      count_high_next = sfr_wdata;
    end

    // Capture pair: a capture wins over a software write
    capture_reload_low_next  = capture_reload_low_reg;
    capture_reload_high_next = capture_reload_high_reg;
    if (capture_ev) begin
      capture_reload_low_next  = count[7:0];
      capture_reload_high_next = count[15:8];
    end else begin
      if (sfr_wr && hit_cap_low) begin
        capture_reload_low_next = sfr_wdata;
      end
      if (sfr_wr && hit_cap_high) begin
        capture_reload_high_next = sfr_wdata;
      end
    end

    // Read data; unmapped addresses read as zero
    sfr_rdata_next = sfr_rdata_reg;
    if (sfr_rd) begin
      case (1'b1)
        hit_control:  sfr_rdata_next = timer_control_reg;
        hit_cap_low:  sfr_rdata_next = capture_reload_low_reg;
        hit_cap_high: sfr_rdata_next = capture_reload_high_reg;
        hit_cnt_low:  sfr_rdata_next = count_low_reg;
        hit_cnt_high: sfr_rdata_next = count_high_reg;
        default:      sfr_rdata_next = `CRBT_BYTE_RESET;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State update
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      timer_control_reg       <= `CRBT_CTRL_RESET;
      capture_reload_low_reg  <= `CRBT_BYTE_RESET;
      capture_reload_high_reg <= `CRBT_BYTE_RESET;
      count_low_reg           <= `CRBT_BYTE_RESET;
      count_high_reg          <= `CRBT_BYTE_RESET;
      sfr_rdata_reg           <= `CRBT_BYTE_RESET;
    end else begin
      timer_control_reg       <= timer_control_next;
      capture_reload_low_reg  <= capture_reload_low_next;
      capture_reload_high_reg <= capture_reload_high_next;
      count_low_reg           <= count_low_next;
      count_high_reg          <= count_high_next;
      sfr_rdata_reg           <= sfr_rdata_next;
    end
  end

endmodule : crbt_timer

`default_nettype wire

// >>> tb/crbt_timer_asserts.sv
// Port-level assertions for the capture/reload/baud timer
`include "crbt_defines.svh"
`default_nettype none

module crbt_timer_asserts #(
  parameter int DIV_SLOW = 12
) (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 resetn,
  // Register access
  input wire logic [7:0]           sfr_addr,
  input wire crbt_pkg::crbt_byte_t sfr_wdata,
  input wire logic                 sfr_wr,
  input wire logic                 sfr_rd,
  input wire crbt_pkg::crbt_byte_t sfr_rdata,
  input wire logic                 sfr_hit,
  // Configuration and pins
  input wire logic                 clock_divide_select,
  input wire logic                 timer_irq_enable,
  input wire logic                 count_pin,
  input wire logic                 trigger_pin,
  // Shift clocks, interrupt and mode
  input wire logic                 other_timer_overflow,
  input wire logic                 uart_rx_shift_clk,
  input wire logic                 uart_tx_shift_clk,
  input wire logic                 timer_irq_req,
  input wire crbt_pkg::crbt_mode_t timer_mode
);
  import crbt_pkg::*;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  wire w_ctl = sfr_wr && (sfr_addr == `CRBT_ADDR_CONTROL);

  property p_irq_en;
    timer_irq_req |-> timer_irq_enable;
  endproperty
  property p_route;
    timer_mode inside {crbt_mode_capture, crbt_mode_reload} |->
      uart_rx_shift_clk == other_timer_overflow &&
      uart_tx_shift_clk == other_timer_overflow;
  endproperty
  property p_unmapped;
    sfr_rd && !sfr_hit |=> sfr_rdata == 8'h00;
  endproperty
  property p_hold;
    !sfr_rd |=> $stable(sfr_rdata);
  endproperty
  property p_off;
    w_ctl && !sfr_wdata[2] |=> timer_mode == crbt_mode_off;
  endproperty
  property p_baud;
    w_ctl && sfr_wdata[2] && |sfr_wdata[5:4] |=> timer_mode == crbt_mode_baud;
  endproperty
  property p_cap;
    w_ctl && sfr_wdata[5:4] == 2'b00 && sfr_wdata[2] && sfr_wdata[0]
      |=> timer_mode == crbt_mode_capture;
  endproperty
  property p_rel;
    w_ctl && sfr_wdata[5:4] == 2'b00 && sfr_wdata[2] && !sfr_wdata[0]
      |=> timer_mode == crbt_mode_reload;
  endproperty
  property p_hit;
    sfr_hit == (sfr_addr inside {`CRBT_ADDR_CONTROL, `CRBT_ADDR_CAP_LOW,
      `CRBT_ADDR_CAP_HIGH, `CRBT_ADDR_CNT_LOW, `CRBT_ADDR_CNT_HIGH});
  endproperty
  property p_irq_hold;
    $fell(timer_irq_req) |-> $fell(timer_irq_enable) || $past(w_ctl);
  endproperty
  property p_pulse;
    timer_mode == crbt_mode_baud && uart_tx_shift_clk |=> !uart_tx_shift_clk;
  endproperty

  a_irq_en: assert property (p_irq_en) else $error("irq without enable");
  a_route: assert property (p_route) else $error("uart clock route");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_off: assert property (p_off) else $error("mode not off");
  a_baud: assert property (p_baud) else $error("mode not baud");
  a_cap: assert property (p_cap) else $error("mode not capture");
  a_rel: assert property (p_rel) else $error("mode not reload");
  a_hit: assert property (p_hit) else $error("address decode");
  a_irq_hold: assert property (p_irq_hold) else $error("flag lost");
  a_pulse: assert property (p_pulse) else $error("shift clock width");

  c_irq: cover property ($rose(timer_irq_req));
  c_baud: cover property (timer_mode == crbt_mode_baud && uart_rx_shift_clk);
  c_cap: cover property (timer_mode == crbt_mode_capture && timer_irq_req);
endmodule : crbt_timer_asserts

bind crbt_timer crbt_timer_asserts #(.DIV_SLOW(DIV_SLOW)) u_chk (
  .clk(clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
  .sfr_hit(sfr_hit), .clock_divide_select(clock_divide_select),
  .timer_irq_enable(timer_irq_enable), .count_pin(count_pin),
  .trigger_pin(trigger_pin), .other_timer_overflow(other_timer_overflow),
  .uart_rx_shift_clk(uart_rx_shift_clk),
  .uart_tx_shift_clk(uart_tx_shift_clk), .timer_irq_req(timer_irq_req),
  .timer_mode(timer_mode));

`default_nettype wire

// >>> tb/crbt_partner.sv
// Far-side model: event pins, other timer overflow, shift clock counters
`default_nettype none

module crbt_partner (
  // Clock
  input  wire logic clk,
  // Shift clocks from the timer
  input  wire logic uart_rx_shift_clk,
  input  wire logic uart_tx_shift_clk,
  // Pins toward the timer
  output var logic  count_pin,
  output var logic  trigger_pin,
  output var logic  other_timer_overflow
);
  timeunit 1ns;
  timeprecision 1ps;

  int n_rx = 0;
  int n_tx = 0;

  initial begin
    count_pin = 1'b1;
    trigger_pin = 1'b1;
    other_timer_overflow = 1'b0;
  end

  always @(posedge clk) begin
    if (uart_rx_shift_clk) n_rx++;
    if (uart_tx_shift_clk) n_tx++;
  end

  // Low and high phases both span four clocks, beyond the synchroniser
  task automatic fall(input bit trig);
    @(posedge clk);
    #1;
    if (trig) trigger_pin = 1'b0;
    else count_pin = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    trigger_pin = 1'b1;
    count_pin = 1'b1;
    repeat (4) @(posedge clk);
  endtask : fall

  task automatic pulse_other;
    @(posedge clk);
    #1;
    other_timer_overflow = 1'b1;
    @(posedge clk);
    #1;
    other_timer_overflow = 1'b0;
  endtask : pulse_other
endmodule : crbt_partner

`default_nettype wire

// >>> tb/test_capture_reload_baud_timer.sv
// Self-checking testbench for the capture/reload/baud timer
`include "crbt_defines.svh"
`default_nettype none

module test_capture_reload_baud_timer;
  timeunit 1ns;
  timeprecision 1ps;
  import crbt_pkg::*;

  localparam logic [7:0] ADR [5] = '{`CRBT_ADDR_CONTROL, `CRBT_ADDR_CAP_LOW,
    `CRBT_ADDR_CAP_HIGH, `CRBT_ADDR_CNT_LOW, `CRBT_ADDR_CNT_HIGH};

  logic       clk;
  logic       resetn;
  logic [7:0] sfr_addr;
  crbt_byte_t sfr_wdata;
  logic       sfr_wr;
  logic       sfr_rd;
  logic       clock_divide_select;
  logic       timer_irq_enable;
  crbt_byte_t sfr_rdata;
  logic       sfr_hit, count_pin, trigger_pin, other_timer_overflow;
  logic       uart_rx_shift_clk, uart_tx_shift_clk, timer_irq_req;
  crbt_mode_t timer_mode;
  int         n_errors = 0;
  int         n_checks = 0;
  crbt_byte_t exp_q[$];
  logic       rd_d = 1'b0;
  crbt_byte_t r;
  logic [15:0] rv;

  crbt_timer #(.DIV_SLOW(12)) dut (
    .clk(clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .clock_divide_select(clock_divide_select),
    .timer_irq_enable(timer_irq_enable), .count_pin(count_pin),
    .trigger_pin(trigger_pin), .other_timer_overflow(other_timer_overflow),
    .uart_rx_shift_clk(uart_rx_shift_clk),
    .uart_tx_shift_clk(uart_tx_shift_clk), .timer_irq_req(timer_irq_req),
    .timer_mode(timer_mode));

  crbt_partner far (
    .clk(clk), .uart_rx_shift_clk(uart_rx_shift_clk),
    .uart_tx_shift_clk(uart_tx_shift_clk), .count_pin(count_pin),
    .trigger_pin(trigger_pin), .other_timer_overflow(other_timer_overflow));

  always #2 clk = ~clk;

  task automatic chk(input string nm, input crbt_byte_t e, input crbt_byte_t g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input crbt_byte_t d);
    @(posedge clk);
    #1;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk);
    #1;
    sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input crbt_byte_t e);
    @(posedge clk);
    #1;
    sfr_addr = a;
    sfr_rd = 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    #1;
    sfr_rd = 1'b0;
  endtask : rd

  // Read data is due one cycle after the read edge
  always @(posedge clk) begin
    rd_d <= sfr_rd;
    if (rd_d) chk("sfr_rdata", exp_q.pop_front(), sfr_rdata);
  end

  task automatic close_out;
    $display("Checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  initial begin
    #40000;
    n_errors++;
    close_out();
  end

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    clock_divide_select = 1'b0;
    timer_irq_enable = 1'b0;
    void'($urandom(32'hc325));
    repeat (6) @(posedge clk);
    #1;
    resetn = 1'b1;
    // ------------------------------------------------------------
    // Reset values, unmapped read, byte access while stopped
    // ------------------------------------------------------------
    foreach (ADR[i]) rd(ADR[i], 8'h00);
    rd(8'hC0 + 8'($urandom % 8), 8'h00);
    for (int i = 1; i < 5; i++) begin
      r = 8'($urandom);
      wr(ADR[i], r);
      rd(ADR[i], r);
    end
    // ------------------------------------------------------------
    // Auto-reload from the system clock, slow then fast
    // ------------------------------------------------------------
    timer_irq_enable = 1'b1;
    wr(ADR[1], 8'hFF);
    wr(ADR[2], 8'hFF);
    wr(ADR[3], 8'hF0);
    wr(ADR[4], 8'hFF);
    wr(ADR[0], 8'h04);
    repeat (60) @(posedge clk);
    rd(ADR[0], 8'h04);
    chk("timer_mode", {6'h00, crbt_mode_reload}, {6'h00, timer_mode});
    clock_divide_select = 1'b1;
    repeat (40) @(posedge clk);
    rd(ADR[0], 8'h84);
    rd(ADR[3], 8'hFF);
    rd(ADR[4], 8'hFF);
    chk("timer_irq_req", 8'h01, {7'h00, timer_irq_req});
    timer_irq_enable = 1'b0;
    @(posedge clk);
    #1;
    chk("timer_irq_req", 8'h00, {7'h00, timer_irq_req});
    timer_irq_enable = 1'b1;
    // First clear meets a same-cycle wrap, so the flag survives it
    wr(ADR[0], 8'h00);
    wr(ADR[0], 8'h00);
    chk("timer_irq_req", 8'h00, {7'h00, timer_irq_req});
    rd(ADR[0], 8'h00);
    // ------------------------------------------------------------
    // Capture of count pin events
    // ------------------------------------------------------------
    wr(ADR[3], 8'h34);
    wr(ADR[4], 8'h12);
    wr(ADR[0], 8'h0F);
    repeat (3) far.fall(1'b0);
    far.fall(1'b1);
    rd(ADR[1], 8'h37);
    rd(ADR[2], 8'h12);
    rd(ADR[0], 8'h4F);
    chk("timer_irq_req", 8'h01, {7'h00, timer_irq_req});
    chk("timer_mode", {6'h00, crbt_mode_capture}, {6'h00, timer_mode});
    wr(ADR[0], 8'h07);
    far.fall(1'b0);
    far.fall(1'b1);
    rd(ADR[1], 8'h37);
    rd(ADR[0], 8'h07);
    wr(ADR[3], 8'hFF);
    wr(ADR[4], 8'hFF);
    far.fall(1'b0);
    rd(ADR[3], 8'h00);
    rd(ADR[4], 8'h00);
    rd(ADR[0], 8'h87);
    // ------------------------------------------------------------
    // Reload forced by the trigger pin
    // ------------------------------------------------------------
    rv = 16'($urandom);
    wr(ADR[1], rv[7:0]);
    wr(ADR[2], rv[15:8]);
    wr(ADR[0], 8'h0E);
    far.fall(1'b1);
    rd(ADR[3], rv[7:0]);
    rd(ADR[4], rv[15:8]);
    rd(ADR[0], 8'h4E);
    // ------------------------------------------------------------
    // Baud-rate generation and shift clock routing
    // ------------------------------------------------------------
    wr(ADR[1], 8'hFE);
    wr(ADR[2], 8'hFF);
    wr(ADR[3], 8'hFE);
    wr(ADR[4], 8'hFF);
    wr(ADR[0], 8'h3F);
    far.n_rx = 0;
    far.n_tx = 0;
    repeat (4) far.fall(1'b0);
    chk("n_rx", 8'h02, far.n_rx[7:0]);
    chk("n_tx", 8'h02, far.n_tx[7:0]);
    chk("timer_mode", {6'h00, crbt_mode_baud}, {6'h00, timer_mode});
    rd(ADR[0], 8'h3F);
    far.fall(1'b1);
    rd(ADR[0], 8'h7F);
    wr(ADR[0], 8'h16);
    far.n_rx = 0;
    far.n_tx = 0;
    far.pulse_other();
    #1;
    chk("n_rx", 8'h01, far.n_rx[7:0]);
    chk("n_tx", 8'h00, far.n_tx[7:0]);
    wr(ADR[0], 8'h26);
    far.n_rx = 0;
    far.n_tx = 0;
    far.pulse_other();
    #1;
    chk("n_rx", 8'h00, far.n_rx[7:0]);
    chk("n_tx", 8'h01, far.n_tx[7:0]);
    wr(ADR[1], 8'hFF);
    wr(ADR[0], 8'h34);
    repeat (10) @(posedge clk);
    #1;
    far.n_rx = 0;
    repeat (40) @(posedge clk);
    #1;
    chk("n_rx", 8'h14, far.n_rx[7:0]);
    rd(ADR[0], 8'h34);
    repeat (4) @(posedge clk);
    close_out();
  end
endmodule : test_capture_reload_baud_timer

`default_nettype wire
